/* logic/tbcs_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tbcs_consts.svh"
module tbcs_core #(
	parameter int unsigned TURN_CYC = `TBCS_TR0_CYC // Turnaround, shorten in simulation
) (
	input  wire logic            mclk,       // 50 MHz clock
	input  wire logic            rst_b,      // Async reset, active low (field power-up)
	input  wire logic      [63:0] uid,       // Factory unique identifier
	input  wire logic       [7:0] afi,       // Factory application family code
	input  wire logic            rx_start,   // Pulse: new request frame begins
	input  wire logic       [7:0] rx_data,   // Received byte, CRC removed
	input  wire logic            rx_valid,   // Pulse: rx_data is valid
	input  wire logic            rx_end,     // Pulse: frame ended
	input  wire logic            rx_crc_ok,  // With rx_end: CRC was correct
	input  wire logic            tx_ready,   // Framer accepts tx_data
	output logic            [7:0] tx_data,   // Response byte
	output logic                 tx_valid,   // Response byte available
	output logic                 tx_last,    // Last byte of response
	output tbcs_pkg::tbcs_card_t card_state, // Current card state
	output logic            [3:0] cid,       // Assigned card identifier
	output logic            [1:0] rate_resp, // Response rate code
	output logic            [1:0] rate_req,  // Request rate code
	output logic                 busy        // Turnaround or sending
);
	import tbcs_pkg::*;

	typedef struct packed {
		tbcs_phase_t         phase; // Receive, turnaround, send
		tbcs_card_t          card;  // Card protocol state
		logic          [3:0] cid;   // Stored identifier
		logic          [1:0] rresp; // Response rate
		logic          [1:0] rreq;  // Request rate
		logic [10:0][7:0]    buf_b; // Received bytes
		logic          [4:0] rcnt;  // Received byte count, saturating
		tbcs_resp_t          kind;  // Pending response type
		logic          [3:0] tlen;  // Pending response length
		logic          [3:0] tidx;  // Next byte to load
		logic         [12:0] wcnt;  // Turnaround counter
		logic          [7:0] txd;   // Output byte
		logic                txv;   // Output valid
		logic                txl;   // Output last
		logic                bsy;   // Turnaround or sending, kept as its own flop
	} tbcs_st_t;

	tbcs_st_t   st_reg;  // Registered state
	tbcs_st_t   st_next; // Next state
	logic [3:0] rnd;     // Random draw source

	localparam logic [12:0] TURN_LAST = 13'(TURN_CYC - 1); // Final turnaround count

	tbcs_lfsr u_lfsr (
		.mclk  (mclk),
		.rst_b (rst_b),
		.rnd   (rnd)
	);

	// Family filter: 00h all, low nibble zero matches high nibble only
	function automatic logic afi_hit(input logic [7:0] req, input logic [7:0] own);
		if (req == 8'h00)
			return 1'b1;
		else if (req[3:0] == 4'h0)
			return req[7:4] == own[7:4];
		else
			return req == own;
	endfunction

	// PUPI compare against the low four identifier bytes, first byte least significant
	function automatic logic pupi_hit(input logic [10:0][7:0] b, input logic [63:0] id);
		return {b[4], b[3], b[2], b[1]} == id[31:0];
	endfunction

	// Response byte generator for a given type and index
	function automatic logic [7:0] resp_byte(input tbcs_resp_t k, input logic [3:0] i,
		input tbcs_st_t s, input logic [63:0] id);
		logic [7:0] r;
		r = 8'h00;
		unique case (k)
			TBCS_R_HALT:
				r = `TBCS_IND_HALT;
			TBCS_R_ATQB:
				if (i == 4'h0)
					r = `TBCS_IND_ATQB;
				else if (i <= 4'h8)
					r = id[8*(i-4'h1) +: 8];
				else if (i == 4'h9)
					r = `TBCS_PROTO_0;
				else if (i == 4'ha)
					r = `TBCS_PROTO_1;
				else
					r = `TBCS_PROTO_2;
			TBCS_R_ATTR:
				if (i == 4'h0)
					r = {4'h0, s.cid};
				else if (i == 4'h1)
					r = `TBCS_HL_OK;
				else
					r = id[8*(i-4'h2) +: 8];
			TBCS_R_ECHO:
				r = s.buf_b[i];
		endcase
		return r;
	endfunction

	// Draw hit: R in 1..N, answer when R is 1, N = 2^code
	function automatic logic draw_one(input logic [2:0] code, input logic [3:0] r);
		logic [3:0] mask;
		mask = 4'((5'h01 << code) - 5'h01);
		return (r & mask) == 4'h0;
	endfunction

	// Main next-state logic
	always_comb
	begin
		logic       go;   // Start a response
		logic       wake; // Request is a wake-up
		tbcs_card_t ncard;
		go    = 1'b0;
		wake  = st_reg.buf_b[2][`TBCS_WUP_BIT];
		ncard = st_reg.card;
		st_next = st_reg;
		unique case (st_reg.phase)
			TBCS_RX:
			begin
				// Collect request bytes; frame start restarts the buffer
				if (rx_start)
					st_next.rcnt = 5'h00;
				else if (rx_valid && st_reg.rcnt != 5'h1f)
				begin
					if (st_reg.rcnt < 5'(`TBCS_BUF_BYTES))
						st_next.buf_b[st_reg.rcnt[3:0]] = rx_data;
					st_next.rcnt = st_reg.rcnt + 5'h01;
				end
				// Decode at frame end; failed CRC leaves everything alone
				if (rx_end && rx_crc_ok)
				begin
					unique case (st_reg.buf_b[0])
						`TBCS_CMD_REQ:
							// Request/wake-up; active cards and halted on plain request skip
							if (st_reg.rcnt == `TBCS_LEN_REQ
								&& st_reg.buf_b[2][7:4] == 4'h0
								&& st_reg.buf_b[2][2:0] <= `TBCS_N_MAX_CODE
								&& afi_hit(st_reg.buf_b[1], afi)
								&& st_reg.card != TBCS_ACTIVE
								&& (wake || st_reg.card != TBCS_HALT))
							begin
								ncard = TBCS_READY;
								// One slot answers at once, else only on a draw of one
								if (st_reg.buf_b[2][2:0] == 3'h0)
									go = 1'b1;
								else if (draw_one(st_reg.buf_b[2][2:0], rnd))
									go = 1'b1;
								st_next.kind = TBCS_R_ATQB;
								st_next.tlen = `TBCS_LEN_ATQB;
							end
						`TBCS_CMD_HALT:
							// Halt only from idle/ready and only with own PUPI
							if (st_reg.rcnt == `TBCS_LEN_HALT
								&& (st_reg.card == TBCS_IDLE || st_reg.card == TBCS_READY)
								&& pupi_hit(st_reg.buf_b, uid))
							begin
								ncard = TBCS_HALT;
								go = 1'b1;
								st_next.kind = TBCS_R_HALT;
								st_next.tlen = 4'h1;
							end
						`TBCS_CMD_ATTR:
							// Param one ignored; TR0/TR1 fixed by the turnaround count
							if (st_reg.rcnt >= `TBCS_LEN_ATTR
								&& (st_reg.card == TBCS_IDLE || st_reg.card == TBCS_READY)
								&& pupi_hit(st_reg.buf_b, uid))
							begin
								st_next.rresp = st_reg.buf_b[6][7:6];
								st_next.rreq  = st_reg.buf_b[6][5:4];
								st_next.cid   = st_reg.buf_b[8][3:0];
								ncard = TBCS_ACTIVE;
								go = 1'b1;
								st_next.kind = TBCS_R_ATTR;
								// Only a lone get-identifier code earns the extra field
								if (st_reg.rcnt == `TBCS_LEN_ATTR_HL
									&& st_reg.buf_b[9] == `TBCS_HL_GETUID)
									st_next.tlen = `TBCS_LEN_UIDR;
								else
									st_next.tlen = 4'h1;
							end
						`TBCS_CMD_DESEL:
							// Deselect only while active, with matching CID, or with no CID when the stored CID is zero
							if (st_reg.card == TBCS_ACTIVE
								&& ((st_reg.rcnt == 5'h01 && st_reg.cid == 4'h0)
								|| (st_reg.rcnt == 5'h02
								&& st_reg.buf_b[1] == {4'h0, st_reg.cid})))
							begin
								ncard = TBCS_HALT;
								go = 1'b1;
								st_next.kind = TBCS_R_ECHO;
								st_next.tlen = 4'(st_reg.rcnt);
							end
						default:
							go = 1'b0; // Unknown command, silent
					endcase
					st_next.card = ncard;
					if (go)
					begin
						st_next.phase = TBCS_TURN;
						st_next.bsy   = 1'b1;
						st_next.wcnt  = 13'h0000;
						st_next.tidx  = 4'h0;
					end
				end
			end
			TBCS_TURN:
			begin
				// Fixed turnaround before the first byte
				if (st_reg.wcnt == TURN_LAST)
				begin
					st_next.phase = TBCS_SEND;
					st_next.txd   = resp_byte(st_reg.kind, 4'h0, st_reg, uid);
					st_next.txv   = 1'b1;
					st_next.txl   = st_reg.tlen == 4'h1;
					st_next.tidx  = 4'h1;
				end
				else
					st_next.wcnt = st_reg.wcnt + 13'h0001;
			end
			TBCS_SEND:
			begin
				// Hand bytes out; requests arriving now are dropped
				if (tx_ready)
				begin
					if (st_reg.txl)
					begin
						st_next.phase = TBCS_RX;
						st_next.bsy   = 1'b0;
						st_next.txv   = 1'b0;
						st_next.txl   = 1'b0;
						st_next.rcnt  = 5'h00;
					end
					else
					begin
						st_next.txd  = resp_byte(st_reg.kind, st_reg.tidx, st_reg, uid);
						st_next.txl  = st_reg.tidx + 4'h1 == st_reg.tlen;
						st_next.tidx = st_reg.tidx + 4'h1;
					end
				end
			end
			default:
				st_next.phase = TBCS_RX; // Unused phase code recovers
		endcase
	end

	// State register; all fields cleared at power-up
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg       <= '0;
			st_reg.phase <= TBCS_RX;
			st_reg.card  <= TBCS_IDLE;
			st_reg.kind  <= TBCS_R_ATQB;
		end
		else
			st_reg <= st_next;
	end

	assign tx_data    = st_reg.txd;
	assign tx_valid   = st_reg.txv;
	assign tx_last    = st_reg.txl;
	assign card_state = st_reg.card;
	assign cid        = st_reg.cid;
	assign rate_resp  = st_reg.rresp;
	assign rate_req   = st_reg.rreq;
	assign busy       = st_reg.bsy;
endmodule // tbcs_core
`default_nettype wire

/* logic/tbcs_consts.svh */
`ifndef TBCS_CONSTS_SVH
`define TBCS_CONSTS_SVH

`define TBCS_CMD_REQ      8'h05
`define TBCS_CMD_HALT     8'h50
`define TBCS_CMD_ATTR     8'h1d
`define TBCS_CMD_DESEL    8'hc2
`define TBCS_HL_GETUID    8'h30
`define TBCS_IND_HALT     8'h00
`define TBCS_IND_ATQB     8'h50
`define TBCS_HL_OK        8'h00
`define TBCS_PROTO_0      8'h77
`define TBCS_PROTO_1      8'h11
`define TBCS_PROTO_2      8'h61
`define TBCS_WUP_BIT      3
`define TBCS_N_MAX_CODE   3'h4
`define TBCS_LEN_REQ      5'h03
`define TBCS_LEN_HALT     5'h05
`define TBCS_LEN_ATTR     5'h09
`define TBCS_LEN_ATTR_HL  5'h0a
`define TBCS_LEN_ATQB     4'hc
`define TBCS_LEN_UIDR     4'ha
`define TBCS_BUF_BYTES    11
`define TBCS_CLK_NS       20
`define TBCS_TR0_NS       151000
`define TBCS_TR0_CYC      ((`TBCS_TR0_NS + `TBCS_CLK_NS - 1) / `TBCS_CLK_NS)
`define TBCS_LFSR_SEED    16'hace1
`define TBCS_LFSR_TAPS    16'hb400

`endif

/* logic/tbcs_pkg.sv */
package tbcs_pkg;
	typedef enum logic [1:0] {TBCS_IDLE, TBCS_READY, TBCS_HALT, TBCS_ACTIVE} tbcs_card_t;
	typedef enum logic [1:0] {TBCS_RX, TBCS_TURN, TBCS_SEND} tbcs_phase_t;
	typedef enum logic [1:0] {TBCS_R_ATQB, TBCS_R_HALT, TBCS_R_ATTR, TBCS_R_ECHO} tbcs_resp_t;
endpackage : tbcs_pkg

/* logic/tbcs_lfsr.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tbcs_consts.svh"
module tbcs_lfsr (
	input  wire logic       mclk,  // System clock
	input  wire logic       rst_b, // Async reset, active low
	output logic      [3:0] rnd    // Free-running random nibble
);
	typedef struct packed {
		logic [15:0] sr; // Galois shift register
	} tbcs_lfsr_st_t;

	tbcs_lfsr_st_t st_reg; // Registered state
	tbcs_lfsr_st_t st_next; // Next state

	// Advance every cycle; reader timing jitter decorrelates the sample point
	always_comb
	begin
		st_next = st_reg;
		st_next.sr = {1'b0, st_reg.sr[15:1]} ^ (st_reg.sr[0] ? `TBCS_LFSR_TAPS : 16'h0000);
	end

	// State register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st_reg <= '{sr: `TBCS_LFSR_SEED};
		else
			st_reg <= st_next;
	end

	assign rnd = st_reg.sr[3:0];
endmodule // tbcs_lfsr
`default_nettype wire

/* verif/tbcs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module tbcs_chk
	import tbcs_pkg::*;
#(
	parameter int TURN_CYC = 4 // Turnaround count handed on from the core
) (
	input  wire logic       mclk,       // Card clock
	input  wire logic       rst_b,      // Async reset, active low
	input  wire logic       rx_end,     // Frame end pulse
	input  wire logic       rx_crc_ok,  // Frame check result
	input  wire logic       tx_ready,   // Reader accepts byte
	input  wire logic [7:0] tx_data,    // Response byte
	input  wire logic       tx_valid,   // Response byte valid
	input  wire logic       tx_last,    // Last response byte
	input  wire tbcs_card_t card_state, // Card state
	input  wire logic [3:0] cid,        // Stored card identifier
	input  wire logic [1:0] rate_resp,  // Response rate code
	input  wire logic [1:0] rate_req,   // Request rate code
	input  wire logic       busy        // Turnaround or sending
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Answers start a fixed turnaround after the card goes busy
	a_turn_time: assert property ($rose(busy) |-> ##TURN_CYC $rose(tx_valid))
		else $error("Turnaround length wrong");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last)) else $error("Response byte not held");
	a_last_done: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid && !busy)
		else $error("Response did not end");
	a_halt_reply: assert property ($rose(tx_valid) && card_state == TBCS_HALT
		|-> (tx_data == 8'h00 && tx_last) || tx_data == 8'hc2) else $error("Halt reply wrong");
	a_ready_atqb: assert property ($rose(tx_valid) && card_state == TBCS_READY
		|-> tx_data == 8'h50 && !tx_last) else $error("Request answer wrong");
	a_attr_ind: assert property ($rose(tx_valid) && card_state == TBCS_ACTIVE
		|-> tx_data == {4'h0, cid}) else $error("Attribute indicator wrong");
	a_crc_silent: assert property (rx_end && !rx_crc_ok && !busy
		|=> !busy && $stable(card_state) && $stable(cid)) else $error("Bad frame acted on");
	a_state_cause: assert property ($changed(card_state) |-> $past(rx_end))
		else $error("State moved without a frame");
	a_desel_halt: assert property ($changed(card_state) && $past(card_state) == TBCS_ACTIVE
		|-> card_state == TBCS_HALT) else $error("Active card left to wrong state");
	a_no_wake_attr: assert property ($changed(card_state) && card_state == TBCS_ACTIVE
		|-> $past(card_state) != TBCS_HALT) else $error("Halted card was selected");
	a_cid_set: assert property ($changed(cid) || $changed(rate_resp) || $changed(rate_req)
		|-> card_state == TBCS_ACTIVE) else $error("Identifier or rates moved outside select");
	// Main scenarios seen
	c_atqb: cover property ($rose(tx_valid) && card_state == TBCS_READY);
	c_attr: cover property ($rose(tx_valid) && card_state == TBCS_ACTIVE);
	c_halt: cover property ($rose(tx_valid) && card_state == TBCS_HALT);
endmodule // tbcs_chk

bind tbcs_core tbcs_chk #(.TURN_CYC(TURN_CYC)) i_tbcs_chk (.mclk(mclk), .rst_b(rst_b),
	.rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_last(tx_last), .card_state(card_state), .cid(cid),
	.rate_resp(rate_resp), .rate_req(rate_req), .busy(busy));
`default_nettype wire

/* verif/tbcs_reader.sv */
`timescale 1ns/1ns
`default_nettype none
module tbcs_reader (
	input  wire logic       mclk,      // Card clock
	input  wire logic [7:0] tx_data,   // Card response byte
	input  wire logic       tx_valid,  // Card response valid
	input  wire logic       tx_last,   // Card last byte
	input  wire logic       busy,      // Card turnaround or sending
	input  wire logic       slow,      // Stall the response path
	output logic            rx_start,  // Frame start pulse
	output logic      [7:0] rx_data,   // Request byte
	output logic            rx_valid,  // Byte strobe
	output logic            rx_end,    // Frame end pulse
	output logic            rx_crc_ok, // Frame check result
	output logic            tx_ready   // Accept response byte
);
	logic [8:0] rsp[$]; // Captured {last, byte} pairs
	initial {rx_start, rx_data, rx_valid, rx_end, rx_crc_ok, tx_ready} = '0;
	// Stall every other cycle when slow, so held outputs get exercised
	always @(negedge mclk)
	begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// Collect what the card hands over
	always @(posedge mclk)
	begin
		if (tx_valid && tx_ready)
			rsp.push_back({tx_last, tx_data});
	end
	// One frame: start, bytes, then end on the cycle after the last byte; idle data lines show junk, not the last byte
	task automatic send(input logic [87:0] q, input int n, input logic c, output logic ok);
		int i;
		rsp.delete();
		@(negedge mclk) rx_start = 1'b1;
		for (i = 0; i < n; i++)
		begin
			@(negedge mclk) {rx_start, rx_valid, rx_data} = {2'b01, q[8*i +: 8]};
		end
		@(negedge mclk) {rx_valid, rx_data, rx_end, rx_crc_ok} = {1'b0, ~rx_data, 1'b1, c};
		@(negedge mclk) {rx_end, rx_crc_ok} = {1'b0, ~c};
		ok = 1'b0;
		// Bounded wait for the card to finish answering
		for (i = 0; i < 200 && !ok; i++)
			@(negedge mclk) ok = !busy && !tx_valid;
	endtask
endmodule // tbcs_reader
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import tbcs_pkg::*;
	typedef struct {logic [87:0] q; int n; logic c; int k; tbcs_card_t s;} tbcs_row_t;
	localparam logic [63:0] UID = 64'h8877665544332211;     // Test identifier
	localparam logic [39:0] HT = {UID[31:0], 8'h50};        // Halt, own PUPI
	localparam logic [23:0] RQ = 24'h000005;                // Request, any family, one slot
	localparam logic [23:0] WU = 24'h080005;                // Wake-up, one slot
	localparam logic [79:0] A0 = {32'h3100_01f5, 8'h00, HT[39:8], 8'h1d};
	localparam logic [79:0] A1 = {32'h3005_019a, 8'hff, HT[39:8], 8'h1d};
	logic mclk, rst_b, slow, rx_start, rx_valid, rx_end, rx_crc_ok, tx_ready;
	logic tx_valid, tx_last, busy, ok;
	logic [7:0] rx_data, tx_data; // Request and response bytes
	logic [3:0] cid;              // Stored identifier
	logic [1:0] rate_resp, rate_req; // Rate codes
	tbcs_card_t card_state;       // Card state
	int errors, checks, n1, i;
	// Kinds: 0 silent, 1 request answer, 2 halt, 3 attr plus UID, 4 attr, 5 echo
	tbcs_row_t rows[18] = '{'{24'h004505, 3, 1, 0, TBCS_IDLE}, '{RQ, 3, 1, 1, TBCS_READY},
		'{HT ^ 40'h100, 5, 1, 0, TBCS_READY}, '{HT, 5, 0, 0, TBCS_READY}, '{HT, 5, 1, 2, TBCS_HALT},
		'{RQ, 3, 1, 0, TBCS_HALT}, '{A0, 10, 1, 0, TBCS_HALT}, '{WU, 3, 1, 1, TBCS_READY},
		'{A0, 10, 1, 4, TBCS_ACTIVE}, '{8'hc2, 1, 1, 5, TBCS_HALT}, '{WU, 3, 1, 1, TBCS_READY},
		'{A1, 10, 1, 3, TBCS_ACTIVE}, '{RQ, 3, 1, 0, TBCS_ACTIVE}, '{HT, 5, 1, 0, TBCS_ACTIVE},
		'{8'hc2, 1, 1, 0, TBCS_ACTIVE}, '{16'h04c2, 2, 1, 0, TBCS_ACTIVE},
		'{16'h05c2, 2, 1, 5, TBCS_HALT}, '{24'h0d0005, 3, 1, 0, TBCS_HALT}};
	tbcs_core #(.TURN_CYC(4)) i_tbcs_core (.mclk(mclk), .rst_b(rst_b), .uid(UID), .afi(8'h3a),
		.rx_start(rx_start), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
		.rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .card_state(card_state), .cid(cid), .rate_resp(rate_resp),
		.rate_req(rate_req), .busy(busy));
	tbcs_reader i_tbcs_reader (.mclk(mclk), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .busy(busy), .slow(slow), .rx_start(rx_start), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready));
	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A hang in the card counts as a mismatch and ends the run
	task automatic xfer(input logic [87:0] q, input int n, input logic c);
		i_tbcs_reader.send(q, n, c, ok);
		if (!ok)
		begin
			errors++;
			final_report();
		end
	endtask
	// Expected answer built from the frame formats, then compared byte by byte
	task automatic run_row(input tbcs_row_t r);
		logic [7:0] e[$];
		int j;
		if (r.k == 2) e.push_back(8'h00);
		if (r.k == 3 || r.k == 4) e.push_back({4'h0, r.q[67:64]});
		if (r.k == 1 || r.k == 3) e.push_back(r.k == 1 ? 8'h50 : 8'h00);
		for (j = 0; j < 8 && (r.k == 1 || r.k == 3); j++) e.push_back(UID[8*j +: 8]);
		if (r.k == 1) e = {e, 8'h77, 8'h11, 8'h61};
		for (j = 0; j < r.n && r.k == 5; j++) e.push_back(r.q[8*j +: 8]);
		xfer(r.q, r.n, r.c);
		chk(i_tbcs_reader.rsp.size(), e.size());
		for (j = 0; j < e.size() && j < i_tbcs_reader.rsp.size(); j++)
			chk(i_tbcs_reader.rsp[j], {j == e.size() - 1, e[j]});
		chk(card_state, r.s);
		if (r.k == 3 || r.k == 4)
			chk({cid, rate_resp, rate_req}, {r.q[67:64], r.q[55:52]});
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		{rst_b, slow, errors, checks} = '0;
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		chk({card_state, cid, rate_resp, rate_req, busy}, {TBCS_IDLE, 9'h0});
		foreach (rows[k])
		begin
			slow = k[0];
			run_row(rows[k]);
		end
		// Two slots: the card answers on some draws only, and stays in play
		n1 = 0;
		for (i = 0; i < 32; i++)
		begin
			xfer(24'h090005, 3, 1'b1);
			n1 += (i_tbcs_reader.rsp.size() == 12);
			chk(card_state, TBCS_READY);
		end
		chk(n1 > 0 && n1 < 32, 1);
		// Reset in mid-run clears the selection
		@(negedge mclk) rst_b = 1'b0;
		#1 chk({card_state, cid, rate_resp, rate_req}, {TBCS_IDLE, 8'h0});
		@(negedge mclk) rst_b = 1'b1;
		@(negedge mclk) chk({card_state, cid, busy}, {TBCS_IDLE, 5'h0});
		final_report();
	end
endmodule // tb_top
`default_nettype wire
